// ===== hdl_pkg.sv
// Shared constants, states and carrier types for the half-duplex radio link sequencer.
`default_nettype none
package hdl_pkg;
  // System clock rate, the default serial rate and the bit period derived from them.
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_DEF = 9600;
  localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_DEF;
  localparam int TICK_W = 20;
  // Packet framing bytes and layout.
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] START_BYTE_DEF = 8'h7e;
  localparam int PAYLOAD_BYTES = 4;
  localparam int PAYLOAD_W = PAYLOAD_BYTES * 8;
  localparam logic [2:0] IDX_SYNC = 3'h0;
  localparam logic [2:0] IDX_START = 3'h1;
  localparam logic [2:0] IDX_LAST = 3'h6;
  localparam logic [3:0] UART_STOP_BIT = 4'h9;
  localparam int CNT_W = 24;
  // Sequencer states, walked in a fixed loop while running.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_TX_SWITCH,
    ST_TX_SETTLE,
    ST_SEND,
    ST_RX_SWITCH,
    ST_RX_SETTLE,
    ST_RECEIVE
  } hdl_seq_t;
  // Pins driven toward the radio module.
  typedef struct packed {
    logic transmitter_enable;
    logic receiver_enable;
    logic sleep_control_n;
    logic baseband_input;
  } hdl_pins_t;
  localparam hdl_pins_t PINS_RESET = 4'h1;
  // One received packet as handed to the user.
  typedef struct packed {
    logic valid;
    logic check_err;
    logic [PAYLOAD_W-1:0] payload;
  } hdl_rx_t;
endpackage
`default_nettype wire

// ===== hdl_uart.sv
// Serial byte transmitter and receiver at a fixed bit period.
`timescale 1ns/1ns
`default_nettype none
module hdl_uart #(
  parameter int BIT_CYCLES = hdl_pkg::BIT_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tx_go,
  input wire logic [7:0] tx_byte,
  output logic tx_rdy,
  output logic tx_idle,
  output logic txd,
  input wire logic rxd,
  input wire logic rx_arm,
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  localparam logic [hdl_pkg::TICK_W-1:0] TICK_LAST = hdl_pkg::TICK_W'(BIT_CYCLES - 1);
  localparam logic [hdl_pkg::TICK_W-1:0] TICK_HALF = hdl_pkg::TICK_W'(BIT_CYCLES / 2);

  logic tx_busy_reg, tx_busy_next;
  logic [9:0] tx_sh_reg, tx_sh_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [hdl_pkg::TICK_W-1:0] tx_tick_reg, tx_tick_next;
  logic tx_last;

  // A new byte may be loaded on the last cycle of a stop bit, so bytes follow with no gap.
  assign tx_last = tx_busy_reg && (tx_bit_reg == hdl_pkg::UART_STOP_BIT) && (tx_tick_reg == TICK_LAST);
  assign tx_rdy = !tx_busy_reg || tx_last;
  assign tx_idle = !tx_busy_reg;
  assign txd = tx_sh_reg[0];

  // Transmit shifter: start bit, eight data bits LSB first, stop bit.
  always_comb
  begin
    tx_busy_next = tx_busy_reg;
    tx_sh_next = tx_sh_reg;
    tx_bit_next = tx_bit_reg;
    tx_tick_next = tx_tick_reg;
    if (tx_go && tx_rdy)
    begin
      tx_busy_next = 1'b1;
      tx_sh_next = {1'b1, tx_byte, 1'b0};
      tx_bit_next = 4'h0;
      tx_tick_next = '0;
    end
    else if (tx_busy_reg)
    begin
      if (tx_tick_reg == TICK_LAST)
      begin
        tx_tick_next = '0;
        tx_sh_next = {1'b1, tx_sh_reg[9:1]};
        tx_bit_next = tx_bit_reg + 4'h1;
        if (tx_last)
        begin
          tx_busy_next = 1'b0;
        end
      end
      else
      begin
        tx_tick_next = tx_tick_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= 10'h3ff;
      tx_bit_reg <= 4'h0;
      tx_tick_reg <= '0;
    end
    else
    begin
      tx_busy_reg <= tx_busy_next;
      tx_sh_reg <= tx_sh_next;
      tx_bit_reg <= tx_bit_next;
      tx_tick_reg <= tx_tick_next;
    end
  end

  logic rx_prev_reg, rx_prev_next;
  logic rx_act_reg, rx_act_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [hdl_pkg::TICK_W-1:0] rx_tick_reg, rx_tick_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic rx_stb_reg, rx_stb_next;

  assign rx_byte = rx_sh_reg;
  assign rx_stb = rx_stb_reg;

  // Receiver: a 1-to-0 edge opens a byte; bits are sampled mid-period.
  always_comb
  begin
    rx_prev_next = rxd;
    rx_act_next = rx_act_reg;
    rx_bit_next = rx_bit_reg;
    rx_tick_next = rx_tick_reg;
    rx_sh_next = rx_sh_reg;
    rx_stb_next = 1'b0;
    if (!rx_act_reg)
    begin
      if (rx_arm && rx_prev_reg && !rxd)
      begin
        rx_act_next = 1'b1;
        rx_bit_next = 4'h0;
        rx_tick_next = '0;
      end
    end
    else
    begin
      rx_tick_next = (rx_tick_reg == TICK_LAST) ? '0 : rx_tick_reg + 1'b1;
      if (rx_tick_reg == TICK_LAST)
      begin
        rx_bit_next = rx_bit_reg + 4'h1;
      end
      if (rx_tick_reg == TICK_HALF)
      begin
        if (rx_bit_reg == 4'h0)
        begin
          // A start bit that is high again by mid-period is noise, not a byte.
          rx_act_next = !rxd;
        end
        else if (rx_bit_reg == hdl_pkg::UART_STOP_BIT)
        begin
          rx_act_next = 1'b0;
          rx_stb_next = rxd;
        end
        else
        begin
          rx_sh_next = {rxd, rx_sh_reg[7:1]};
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_prev_reg <= 1'b1;
      rx_act_reg <= 1'b0;
      rx_bit_reg <= 4'h0;
      rx_tick_reg <= '0;
      rx_sh_reg <= 8'h00;
      rx_stb_reg <= 1'b0;
    end
    else
    begin
      rx_prev_reg <= rx_prev_next;
      rx_act_reg <= rx_act_next;
      rx_bit_reg <= rx_bit_next;
      rx_tick_reg <= rx_tick_next;
      rx_sh_reg <= rx_sh_next;
      rx_stb_reg <= rx_stb_next;
    end
  end
endmodule // hdl_uart
`default_nettype wire

// ===== hdl_radio_seq.sv
// Host-side sequencer and packet framer that operates a half-duplex radio module.
// Function
// - Never both enables high together
// - Transmit line must toggle within set interval
// - Transmit mode: transmitter on, receiver off, awake
// - Wait worst-case settling before sending
// - Packet bytes sent back to back
// - Packet is sync, start, then payload
// - Sync byte is ff hex
// - Receive mode: receiver on, transmitter off, awake
// - Ignore recovered data until settling ends
// - Start bit is a falling edge
// - Sync gives one byte of high marking
// - Packets found by matching the start byte
// - Packets carry a check; errors are flagged
// - Fixed loop of transmit and receive phases
`timescale 1ns/1ns
`default_nettype none
module hdl_radio_seq #(
  parameter int BIT_CYCLES = hdl_pkg::BIT_CYCLES_DEF,
  parameter logic [7:0] START_BYTE = hdl_pkg::START_BYTE_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [hdl_pkg::CNT_W-1:0] tx_settle_cycles,
  input wire logic [hdl_pkg::CNT_W-1:0] rx_settle_cycles,
  input wire logic [hdl_pkg::CNT_W-1:0] rx_window_cycles,
  input wire logic tx_valid,
  input wire logic [hdl_pkg::PAYLOAD_W-1:0] tx_payload,
  output logic tx_ready,
  input wire logic recovered_data_out,
  output var hdl_pkg::hdl_pins_t pins,
  output var hdl_pkg::hdl_rx_t rx_out
);
  // Byte at position i of an outgoing frame; the check byte is the payload sum.
  function automatic logic [7:0] hdl_frame_byte(input logic [2:0] i, input logic [31:0] p);
    case (i)
      hdl_pkg::IDX_SYNC: return hdl_pkg::SYNC_BYTE;
      hdl_pkg::IDX_START: return START_BYTE;
      hdl_pkg::IDX_LAST: return p[7:0] + p[15:8] + p[23:16] + p[31:24];
      default: return p[8*(int'(i)-2) +: 8];
    endcase
  endfunction
  // The recovered data pin is asynchronous to the core clock.
  logic rxd_meta_reg, rxd_sync_reg;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end
    else
    begin
      rxd_meta_reg <= recovered_data_out;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end
  hdl_pkg::hdl_seq_t st_reg, st_next;
  logic [hdl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic pend_reg, pend_next;
  logic [hdl_pkg::PAYLOAD_W-1:0] buf_reg, buf_next;
  logic [2:0] idx_reg, idx_next;
  hdl_pkg::hdl_pins_t pins_reg, pins_next;
  logic tx_ready_reg, tx_ready_next;
  logic u_go, u_rdy, u_idle, u_txd, u_stb;
  logic [7:0] u_byte, u_rx_byte;
  hdl_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .core_clk(core_clk),
    .rst(rst),
    .tx_go(u_go),
    .tx_byte(u_byte),
    .tx_rdy(u_rdy),
    .tx_idle(u_idle),
    .txd(u_txd),
    .rxd(rxd_sync_reg),
    .rx_arm(st_reg == hdl_pkg::ST_RECEIVE),
    .rx_byte(u_rx_byte),
    .rx_stb(u_stb)
  );
  assign pins = pins_reg;
  assign tx_ready = tx_ready_reg;
  // While settling the line carries alternating bits, so the carrier never sees a DC level.
  assign u_go = (st_reg == hdl_pkg::ST_TX_SETTLE) || (st_reg == hdl_pkg::ST_SEND && pend_reg);
  assign u_byte = (st_reg == hdl_pkg::ST_SEND) ? hdl_frame_byte(idx_reg, buf_reg) : hdl_pkg::PREAMBLE_BYTE;
  // Mode sequencer: one enable always drops an edge before the other rises.
  always_comb
  begin
    st_next = st_reg;
    cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    pend_next = pend_reg;
    buf_next = buf_reg;
    idx_next = idx_reg;
    pins_next = pins_reg;
    pins_next.baseband_input = u_txd;
    if (tx_valid && tx_ready_reg)
    begin
      pend_next = 1'b1;
      buf_next = tx_payload;
    end
    case (st_reg)
      hdl_pkg::ST_OFF:
      begin
        pins_next.sleep_control_n = 1'b0;
        if (run)
        begin
          st_next = hdl_pkg::ST_TX_SWITCH;
          pins_next.sleep_control_n = 1'b1;
        end
      end
      hdl_pkg::ST_TX_SWITCH:
      begin
        // Sleep release and a receive period that ends with run high both end in the settle wait.
        st_next = hdl_pkg::ST_TX_SETTLE;
        cnt_next = tx_settle_cycles;
        pins_next.transmitter_enable = 1'b1;
        pins_next.sleep_control_n = 1'b1;
      end
      hdl_pkg::ST_TX_SETTLE:
      begin
        if (cnt_reg == '0)
        begin
          st_next = hdl_pkg::ST_SEND;
          idx_next = hdl_pkg::IDX_SYNC;
        end
      end
      hdl_pkg::ST_SEND:
      begin
        if (pend_reg && u_rdy)
        begin
          idx_next = idx_reg + 3'h1;
          if (idx_reg == hdl_pkg::IDX_LAST)
          begin
            pend_next = 1'b0;
          end
        end
        else if (!pend_reg && u_idle)
        begin
          st_next = hdl_pkg::ST_RX_SWITCH;
          pins_next.transmitter_enable = 1'b0;
        end
      end
      hdl_pkg::ST_RX_SWITCH:
      begin
        st_next = hdl_pkg::ST_RX_SETTLE;
        cnt_next = rx_settle_cycles;
        pins_next.receiver_enable = 1'b1;
      end
      hdl_pkg::ST_RX_SETTLE:
      begin
        if (cnt_reg == '0)
        begin
          st_next = hdl_pkg::ST_RECEIVE;
          cnt_next = rx_window_cycles;
        end
      end
      hdl_pkg::ST_RECEIVE:
      begin
        if (cnt_reg == '0)
        begin
          pins_next.receiver_enable = 1'b0;
          st_next = run ? hdl_pkg::ST_TX_SWITCH : hdl_pkg::ST_OFF;
        end
      end
      default:
      begin
        st_next = hdl_pkg::ST_OFF;
        pins_next = hdl_pkg::PINS_RESET;
      end
    endcase
    // A payload is not taken while a frame is being shifted out.
    tx_ready_next = !pend_next && (st_next != hdl_pkg::ST_SEND);
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= hdl_pkg::ST_OFF;
      cnt_reg <= '0;
      pend_reg <= 1'b0;
      buf_reg <= '0;
      idx_reg <= hdl_pkg::IDX_SYNC;
      pins_reg <= hdl_pkg::PINS_RESET;
      tx_ready_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
      buf_reg <= buf_next;
      idx_reg <= idx_next;
      pins_reg <= pins_next;
      tx_ready_reg <= tx_ready_next;
    end
  end
  logic [2:0] ridx_reg, ridx_next;
  logic [hdl_pkg::PAYLOAD_W-1:0] rbuf_reg, rbuf_next;
  logic [7:0] rsum_reg, rsum_next;
  hdl_pkg::hdl_rx_t rx_reg, rx_next;
  assign rx_out = rx_reg;
  // Packet hunter: idle-high and sync bytes are skipped until the start byte matches.
  always_comb
  begin
    ridx_next = ridx_reg;
    rbuf_next = rbuf_reg;
    rsum_next = rsum_reg;
    rx_next = rx_reg;
    rx_next.valid = 1'b0;
    if (st_reg != hdl_pkg::ST_RECEIVE)
    begin
      // A frame cut off by the end of the window is dropped.
      ridx_next = hdl_pkg::IDX_SYNC;
    end
    else if (u_stb)
    begin
      if (ridx_reg == hdl_pkg::IDX_SYNC)
      begin
        if (u_rx_byte == START_BYTE)
        begin
          ridx_next = hdl_pkg::IDX_START + 3'h1;
          rsum_next = 8'h00;
        end
      end
      else if (ridx_reg == hdl_pkg::IDX_LAST)
      begin
        rx_next.valid = 1'b1;
        rx_next.check_err = (u_rx_byte != rsum_reg);
        rx_next.payload = rbuf_reg;
        ridx_next = hdl_pkg::IDX_SYNC;
      end
      else
      begin
        rbuf_next = {u_rx_byte, rbuf_reg[hdl_pkg::PAYLOAD_W-1:8]};
        rsum_next = rsum_reg + u_rx_byte;
        ridx_next = ridx_reg + 3'h1;
      end
    end
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ridx_reg <= hdl_pkg::IDX_SYNC;
      rbuf_reg <= '0;
      rsum_reg <= 8'h00;
      rx_reg <= '0;
    end
    else
    begin
      ridx_reg <= ridx_next;
      rbuf_reg <= rbuf_next;
      rsum_reg <= rsum_next;
      rx_reg <= rx_next;
    end
  end

  // Checks on the pins and the framing.
  a_enables_exclusive: assert property (@(posedge core_clk) disable iff (rst)
    !(pins_reg.transmitter_enable && pins_reg.receiver_enable))
    else $error("both enables high");
  a_tx_rise_clean: assert property (@(posedge core_clk) disable iff (rst)
    $rose(pins_reg.transmitter_enable) |-> !$past(pins_reg.receiver_enable) && $past(st_reg == hdl_pkg::ST_TX_SWITCH))
    else $error("transmit enable rose without clean switch");
  a_rx_rise_clean: assert property (@(posedge core_clk) disable iff (rst)
    $rose(pins_reg.receiver_enable) |-> !$past(pins_reg.transmitter_enable) && st_reg == hdl_pkg::ST_RX_SETTLE)
    else $error("receive enable rose without clean switch");
  a_awake_when_on: assert property (@(posedge core_clk) disable iff (rst)
    (pins_reg.transmitter_enable || pins_reg.receiver_enable) |-> pins_reg.sleep_control_n)
    else $error("enable high while asleep");
  a_settle_holds: assert property (@(posedge core_clk) disable iff (rst)
    (st_reg == hdl_pkg::ST_TX_SETTLE && cnt_reg != '0) |=> st_reg == hdl_pkg::ST_TX_SETTLE)
    else $error("left transmit settle early");
  a_sync_then_start: assert property (@(posedge core_clk) disable iff (rst)
    (st_reg == hdl_pkg::ST_SEND && u_go && u_rdy && idx_reg == hdl_pkg::IDX_SYNC) |->
    u_byte == hdl_pkg::SYNC_BYTE ##1 (idx_reg == hdl_pkg::IDX_START && u_byte == START_BYTE))
    else $error("frame does not open with sync then start");
  a_no_byte_gap: assert property (@(posedge core_clk) disable iff (rst)
    (st_reg == hdl_pkg::ST_SEND && pend_reg && idx_reg != hdl_pkg::IDX_SYNC) |-> !u_idle)
    else $error("gap between frame bytes");
  a_rx_only_window: assert property (@(posedge core_clk) disable iff (rst)
    rx_reg.valid |-> $past(st_reg == hdl_pkg::ST_RECEIVE) && $past(ridx_reg == hdl_pkg::IDX_LAST))
    else $error("packet delivered outside receive window");
  a_loop_order: assert property (@(posedge core_clk) disable iff (rst)
    (st_reg == hdl_pkg::ST_SEND && st_next != hdl_pkg::ST_SEND) |=> st_reg == hdl_pkg::ST_RX_SWITCH ##1
    st_reg == hdl_pkg::ST_RX_SETTLE)
    else $error("mode loop out of order");
endmodule // hdl_radio_seq
`default_nettype wire

// ===== hdl_radio_model.sv
// Behavioural model of the radio module as seen at its control and data pins.
`timescale 1ns/1ns
`default_nettype none
module hdl_radio_model #(
  parameter int TX_LOCK = 30,
  parameter int RX_LOCK = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire hdl_pkg::hdl_pins_t pins,
  input wire logic air_in,
  output logic recovered_data_out,
  output logic tx_locked
);
  int tx_cnt;
  int rx_cnt;
  logic hash_reg;
  logic awake;
  logic rx_ready;
  // A low sleep control powers the module down and throws away any lock.
  assign awake = (pins.sleep_control_n === 1'b1);
  // Lock timers restart whenever the module sleeps or the enable falls.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_cnt <= 0;
      rx_cnt <= 0;
      hash_reg <= 1'b0;
    end
    else
    begin
      hash_reg <= ~hash_reg;
      tx_cnt <= (awake && pins.transmitter_enable) ? tx_cnt + 1 : 0;
      rx_cnt <= (awake && pins.receiver_enable) ? rx_cnt + 1 : 0;
    end
  end
  // Both enables high voids either lock, so the model refuses to be ready then.
  assign tx_locked = awake && pins.transmitter_enable && !pins.receiver_enable
    && tx_cnt >= TX_LOCK;
  assign rx_ready = awake && pins.receiver_enable && !pins.transmitter_enable
    && rx_cnt >= RX_LOCK;
  // Settled data passes untouched; scraps come out while settling; a silent receiver rests high.
  assign recovered_data_out = rx_ready ? air_in
    : ((awake && pins.receiver_enable) ? hash_reg : 1'b1);
endmodule // hdl_radio_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the radio link sequencer against the radio module model.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int BC = 16;
  localparam int CW = hdl_pkg::CNT_W;
  localparam int TXS = 50;
  localparam int RXS = 60;
  localparam int RXW = 2000;
  localparam int LIMIT = 40000;
  localparam logic [7:0] START = hdl_pkg::START_BYTE_DEF;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic tx_valid = 1'b0;
  logic [31:0] tx_payload = 32'h0;
  logic air = 1'b1;
  logic tx_ready;
  logic recovered_data_out;
  logic tx_locked;
  hdl_pkg::hdl_pins_t pins;
  hdl_pkg::hdl_pins_t prev_pins = 4'h1;
  hdl_pkg::hdl_rx_t rx_out;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last_up = 0;
  int rx_len = 0;
  int run_len = 0;
  int max_run = 0;
  int tx_rise = 0;

  always #2 core_clk = ~core_clk;

  hdl_radio_seq #(.BIT_CYCLES(BC), .START_BYTE(START)) hdl_radio_seq_i (
    .core_clk(core_clk), .rst(rst), .run(run),
    .tx_settle_cycles(CW'(TXS)), .rx_settle_cycles(CW'(RXS)), .rx_window_cycles(CW'(RXW)),
    .tx_valid(tx_valid), .tx_payload(tx_payload), .tx_ready(tx_ready),
    .recovered_data_out(recovered_data_out), .pins(pins), .rx_out(rx_out));

  hdl_radio_model hdl_radio_model_i (
    .core_clk(core_clk), .rst(rst), .pins(pins), .air_in(air),
    .recovered_data_out(recovered_data_out), .tx_locked(tx_locked));

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [7:0] csum(input logic [31:0] p);
    return p[7:0] + p[15:8] + p[23:16] + p[31:24];
  endfunction

  // Cycle count; a hang is cut short and judged as a failure.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      mismatches++;
      final_report();
    end
  end

  // Watch enable overlap, mode order, receive length and steady runs on the line.
  always @(negedge core_clk)
  begin
    if (!rst)
    begin
      if (pins.transmitter_enable && pins.receiver_enable)
        check("both enables", 1, 0);
      if (pins.transmitter_enable && !prev_pins.transmitter_enable)
      begin
        check("tx after tx", last_up == 1, 0);
        check("awake in tx", pins.sleep_control_n, 1);
        last_up = 1;
        tx_rise = cyc;
        max_run = 0;
        run_len = 0;
      end
      if (pins.receiver_enable && !prev_pins.receiver_enable)
      begin
        check("rx after tx", last_up == 1, 1);
        check("awake in rx", pins.sleep_control_n, 1);
        last_up = 2;
      end
      if (!pins.receiver_enable && prev_pins.receiver_enable)
        check("rx length", rx_len >= RXS + RXW + 1 && rx_len <= RXS + RXW + 3, 1);
      rx_len = pins.receiver_enable ? rx_len + 1 : 0;
      if (!pins.sleep_control_n && prev_pins.sleep_control_n)
        last_up = 0;
      if (pins.transmitter_enable)
      begin
        run_len = (pins.baseband_input === prev_pins.baseband_input) ? run_len + 1 : 1;
        if (run_len > max_run)
          max_run = run_len;
      end
      prev_pins = pins;
    end
  end

  // Decodes one byte from the line; the high run before its start bit must exceed need.
  task automatic tx_byte(input int need, output logic [7:0] b, output int t, output int h);
    int n;
    h = 0;
    b = 8'h00;
    for (n = 0; n < 3000; n++)
    begin
      @(negedge core_clk);
      if (pins.baseband_input === 1'b1)
        h++;
      else if (h > need)
        break;
      else
        h = 0;
    end
    t = cyc;
    repeat (BC / 2) @(negedge core_clk);
    for (n = 0; n < 8; n++)
    begin
      repeat (BC) @(negedge core_clk);
      b[n] = pins.baseband_input;
    end
    repeat (BC) @(negedge core_clk);
    if (pins.baseband_input !== 1'b1)
      b = 8'hxx;
  endtask

  // Plays one byte into the air; the last byte returns at the stop bit's start.
  task automatic air_byte(input logic [7:0] b, input bit last);
    int i;
    air = 1'b0;
    repeat (BC) @(negedge core_clk);
    for (i = 0; i < 8; i++)
    begin
      air = b[i];
      repeat (BC) @(negedge core_clk);
    end
    air = 1'b1;
    if (!last)
      repeat (BC) @(negedge core_clk);
  endtask

  task automatic test_reset();
    check("reset pins", pins, hdl_pkg::PINS_RESET);
    check("reset ready", tx_ready, 0);
    check("reset rx", rx_out, 0);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    check("wake", pins.sleep_control_n, 1);
    check("ready", tx_ready, 1);
    $display("test reset finished");
  endtask

  task automatic test_tx(input logic [31:0] p);
    logic [7:0] b;
    int t0;
    int t;
    int h;
    int i;
    tx_valid = 1'b1;
    tx_payload = p;
    for (i = 0; i < 6000 && tx_ready !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    tx_valid = 1'b0;
    @(negedge core_clk);
    check("payload held", tx_ready, 0);
    // A payload taken during receive waits for the next transmit phase; the idle line before it
    // must not be mistaken for the sync marking.
    for (i = 0; i < 6000 && pins.transmitter_enable !== 1'b1; i++) @(negedge core_clk);
    tx_byte(8 * BC, b, t0, h);
    check("start byte", b, START);
    check("sync marking", h, 9 * BC);
    check("settle wait", t0 - 10 * BC - tx_rise >= TXS + 1, 1);
    check("carrier locked", tx_locked, 1);
    for (i = 0; i < 5; i++)
    begin
      tx_byte(0, b, t, h);
      check("frame byte", b, i < 4 ? p[8 * i +: 8] : csum(p));
      check("byte spacing", t - t0, 10 * BC * (i + 1));
    end
    check("steady run", max_run <= 10 * BC, 1);
    $display("test transmit finished");
  endtask

  task automatic test_rx(input logic [31:0] p, input bit bad);
    int i;
    for (i = 0; i < 6000 && pins.receiver_enable !== 1'b1; i++) @(negedge core_clk);
    repeat (RXS + 4) @(negedge core_clk);
    air_byte(8'h12, 0);
    air_byte(hdl_pkg::SYNC_BYTE, 0);
    air_byte(START, 0);
    for (i = 0; i < 4; i++)
      air_byte(p[8 * i +: 8], 0);
    air_byte(csum(p) ^ {7'h0, bad}, 1);
    for (i = 0; i < 2 * BC && rx_out.valid !== 1'b1; i++) @(negedge core_clk);
    check("rx valid", rx_out.valid, 1);
    check("rx payload", rx_out.payload, p);
    check("rx check flag", rx_out.check_err, bad);
    $display("test receive finished");
  endtask

  task automatic test_sleep();
    int i;
    run = 1'b0;
    for (i = 0; i < 6000 && pins.sleep_control_n !== 1'b0; i++) @(negedge core_clk);
    check("asleep", pins.sleep_control_n, 0);
    check("enables off", {pins.transmitter_enable, pins.receiver_enable}, 0);
    repeat (30) @(negedge core_clk);
    check("stays asleep", pins.sleep_control_n, 0);
    run = 1'b1;
    for (i = 0; i < 100 && pins.transmitter_enable !== 1'b1; i++) @(negedge core_clk);
    check("tx first", pins.transmitter_enable, 1);
    $display("test sleep finished");
  endtask

  // Main sequence: reset, two transmit and receive rounds, then sleep and wake.
  initial
  begin
    repeat (5) @(negedge core_clk);
    test_reset();
    test_tx(32'h3c5a_96e1);
    test_rx(32'h0f1e_2d3c, 1'b0);
    test_tx(32'h8124_c3a5);
    test_rx(32'h5566_7788, 1'b1);
    test_sleep();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
